// ===== shared/kbpsa_consts.vh
// constants for the keyboard printer serial adapter
`ifndef KBPSA_CONSTS_VH
`define KBPSA_CONSTS_VH

// status byte bit positions
`define KBPSA_ST_OVERRUN   0
`define KBPSA_ST_BREAK     2
`define KBPSA_ST_STANDBY   3
`define KBPSA_ST_BUSY      4
`define KBPSA_ST_SUMMARY   5
`define KBPSA_ST_UNAVAIL   7

// command byte bit positions
`define KBPSA_CMD_DISABLE  0
`define KBPSA_CMD_ENABLE   1
`define KBPSA_CMD_UNBLOCK  2
`define KBPSA_CMD_BLOCK    3
`define KBPSA_CMD_OUTPUT   4
`define KBPSA_CMD_INPUT    5
`define KBPSA_CMD_CTL_LO   6
`define KBPSA_CMD_CTL_HI   7

// control code in command bits 7:6 (bit7, bit6)
`define KBPSA_CTL_SLOW     2'h0
`define KBPSA_CTL_FAST     2'h3
`define KBPSA_CTL_DUR_ON   2'h1
`define KBPSA_CTL_DUR_OFF  2'h2

// timing: base timer rate and system clock
`define KBPSA_CLK_HZ       200000000
`define KBPSA_BASE_HZ      4800
`define KBPSA_BASE_DIV     (`KBPSA_CLK_HZ / `KBPSA_BASE_HZ)
`define KBPSA_PRE_BW       16

// base ticks per bit: divide by 4 (fast) or 16 (slow)
`define KBPSA_SUB_MAX_FAST 4'h3
`define KBPSA_SUB_MAX_SLOW 4'hF
`define KBPSA_SUB_HALF_FAST 4'h2
`define KBPSA_SUB_HALF_SLOW 4'h8

// reset values and buffer shape
`define KBPSA_SHIFT_PRESET 11'h7FF
`define KBPSA_FIFO_DEPTH   16
`define KBPSA_FIFO_AW      4

`endif

// ===== rtl/kbpsa_fifo.v
// transmit byte fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module kbpsa_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rstn,
  input  wire          clear,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);

  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;

  // integer copies so the narrow forms are cut on purpose
  localparam integer  D_ALL  = D;
  localparam integer  D_LAST = D - 1;
  localparam [AW:0]   FULL   = D_ALL[AW:0];
  localparam [AW-1:0] LAST   = D_LAST[AW-1:0];

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // honest flags straight from the occupancy count
  assign in_ready  = (cnt_r != FULL);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];

  // storage has no reset; only pointers and count carry state
  always @(posedge ref_clk)
    if (push)
      mem[wr_r] <= in_data;

  // pointers wrap at the depth, which need not be a power of two
  always @(posedge ref_clk)
    if (!rstn || clear)
    begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == LAST) ? {AW{1'b0}} : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == LAST) ? {AW{1'b0}} : rd_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end

endmodule
`default_nettype wire

// ===== rtl/kbpsa_timer.v
// gated bit timer producing the shift strobe
`timescale 1ns/100ps
`include "kbpsa_consts.vh"
`default_nettype none
module kbpsa_timer #(
  parameter BASE_DIV = `KBPSA_BASE_DIV,
  parameter BW       = `KBPSA_PRE_BW
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // control
  input  wire start,
  input  wire half_first,
  input  wire run,
  input  wire fast,
  // strobe out
  output wire shift_strobe
);

  localparam integer  PRE_MAX_I = BASE_DIV - 1;
  localparam [BW-1:0] PRE_MAX   = PRE_MAX_I[BW-1:0];

  reg [BW-1:0] pre_r;
  reg [3:0]    sub_r;

  wire       base_tick = (pre_r == PRE_MAX);
  wire [3:0] sub_max   = fast ? `KBPSA_SUB_MAX_FAST : `KBPSA_SUB_MAX_SLOW;
  wire [3:0] sub_half  = fast ? `KBPSA_SUB_HALF_FAST : `KBPSA_SUB_HALF_SLOW;

  assign shift_strobe = run & base_tick & (sub_r == sub_max);

  // restart on start so the first strobe is a fixed distance away;
  // a half-bit head start puts receive samples at bit centres
  always @(posedge ref_clk)
    if (!rstn || start || !run)
    begin
      pre_r <= {BW{1'b0}};
      sub_r <= (start && half_first) ? sub_half : 4'h0;
    end
    else if (base_tick)
    begin
      pre_r <= {BW{1'b0}};
      sub_r <= (sub_r == sub_max) ? 4'h0 : sub_r + 4'h1;
    end
    else
      pre_r <= pre_r + 1'b1;

endmodule
`default_nettype wire

// ===== rtl/kbpsa_adapter.v
// keyboard printer serial adapter top
`timescale 1ns/100ps
`include "kbpsa_consts.vh"
`default_nettype none
// Operation
// - serialize output bytes through eleven-stage shifter
// - write presets, loads data, start low, stop
// - shift zeros per strobe, output from start stage
// - end when upper stages empty, one last shift
// - one start, one or two stop bits
// - ten/eleven-bit framing is a static option
// - busy from timer start until shifted out
// - output end clears busy, sets attention
// - switching input to output sets attention
// - clear drops interrupt, input, blocked, disarmed
// - interrupts queue while disabled by default
// - arm option keeps interrupt cleared until armed
// - received byte copied to holding buffer
// - rx from stages 1-8, tx into 1-8
// - status byte bit layout
// - overrun on unread byte, cleared by status read
// - break after spacing longer than character
// - standby flag follows terminal standby state
// - option for seven data bits framing
// - speed control switches rate by four
// - receiver always expects ten-bit frames
// - receive samples at bit centres from start
// - input busy drops while byte waits
module kbpsa_adapter #(
  parameter BASE_DIV   = `KBPSA_BASE_DIV,
  parameter ELEVEN_BIT = 1,
  parameter SEVEN_BIT  = 0,
  parameter SPEED_CTL  = 1,
  parameter ARM_OPT    = 0,
  parameter DUR_CTL    = 0,
  parameter FIFO_DEPTH = `KBPSA_FIFO_DEPTH,
  parameter FIFO_AW    = `KBPSA_FIFO_AW
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       system_clear,
  // processor data path
  input  wire       data_write_strobe,
  input  wire [7:0] write_data,
  output wire       write_ready,
  input  wire       data_read_strobe,
  output wire [7:0] read_data,
  // processor command and status
  input  wire       command_strobe,
  input  wire [7:0] command_data,
  input  wire       status_read_strobe,
  output wire [7:0] status_data,
  input  wire       intr_ack,
  output wire       intr_req,
  // terminal side
  input  wire       serial_rx_in,
  input  wire       standby_in,
  input  wire       unavailable_in,
  output wire       serial_tx_out,
  output wire       data_unit_ready
);

  // frame image for a new output character, already preset and loaded
  function [10:0] load_frame;
    input [7:0] d;
    begin
      if (SEVEN_BIT != 0)
        load_frame = {1'b0, 1'b0, 1'b1, d[6:0], 1'b0};
      else if (ELEVEN_BIT != 0)
        load_frame = {1'b1, 1'b1, d, 1'b0};
      else
        load_frame = {1'b0, 1'b1, d, 1'b0};
    end
  endfunction

  wire clr = !rstn || system_clear;

  // pin synchronisers: stage one feeds stage two only
  reg [2:0] pin_s1_r;
  reg [2:0] pin_s2_r;
  reg       rx_prev_r;

  always @(posedge ref_clk)
    if (!rstn)
    begin
      pin_s1_r  <= 3'h1;
      pin_s2_r  <= 3'h1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      pin_s1_r  <= {unavailable_in, standby_in, serial_rx_in};
      pin_s2_r  <= pin_s1_r;
      rx_prev_r <= pin_s2_r[0];
    end

  wire rx_s      = pin_s2_r[0];
  wire standby_s = pin_s2_r[1];
  wire unavail_s = pin_s2_r[2];
  wire rx_fall   = rx_prev_r & !rx_s;

  // control state
  reg        dir_out_r;
  reg        echo_blk_r;
  reg        int_en_r;
  reg        armed_r;
  reg        attention_ff;
  reg        fast_r;
  reg        dur_r;
  reg        bit_timer_run;
  reg [10:0] shift_r;
  reg [7:0]  rxbuf_r;
  reg        avail_r;
  reg        ovr_r;
  reg        line_break_flag;
  reg        rx_wait_r;
  reg        tx_line_r;
  reg [7:0]  status_r;

  // transmit fifo between the processor and the shifter
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       tx_take = dir_out_r & !bit_timer_run & fifo_valid;

  kbpsa_fifo #(
    .W  (8),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) i_kbpsa_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clear     (system_clear),
    .in_valid  (data_write_strobe),
    .in_ready  (write_ready),
    .in_data   (write_data),
    .out_valid (fifo_valid),
    .out_ready (tx_take),
    .out_data  (fifo_data)
  );

  // receive start: falling edge of start bit on an idle, settled line
  wire rx_start = !dir_out_r & !bit_timer_run & !rx_wait_r & rx_fall;
  wire shift_strobe;

  kbpsa_timer #(
    .BASE_DIV (BASE_DIV),
    .BW       (`KBPSA_PRE_BW)
  ) i_kbpsa_timer (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .start        (tx_take | rx_start),
    .half_first   (rx_start),
    .run          (bit_timer_run),
    .fast         (fast_r),
    .shift_strobe (shift_strobe)
  );

  // command decode
  wire cmd_dis   = command_strobe & command_data[`KBPSA_CMD_DISABLE];
  wire cmd_ena   = command_strobe & command_data[`KBPSA_CMD_ENABLE];
  wire cmd_unblk = command_strobe & command_data[`KBPSA_CMD_UNBLOCK];
  wire cmd_blk   = command_strobe & command_data[`KBPSA_CMD_BLOCK];
  wire cmd_in    = command_strobe & command_data[`KBPSA_CMD_INPUT];
  wire output_direction_cmd = command_strobe &
                              command_data[`KBPSA_CMD_OUTPUT] &
                              !command_data[`KBPSA_CMD_INPUT];
  wire ctl_bit_six   = command_data[`KBPSA_CMD_CTL_LO];
  wire ctl_bit_seven = command_data[`KBPSA_CMD_CTL_HI];
  wire [1:0] ctl_code = {ctl_bit_seven, ctl_bit_six};

  wire to_out  = output_direction_cmd & !dir_out_r;
  wire dir_chg = to_out | (cmd_in & dir_out_r);

  // receive shift: sample enters stage nine, start marker walks down
  wire [10:0] rx_nxt = {1'b0, rx_s, shift_r[9:1]};
  wire        rx_end = shift_strobe & !dir_out_r &
                       !shift_r[1];
  wire        rx_is_break = !rx_s && (rx_nxt[8:1] == 8'h00);
  // output end: nothing but the bit on the line is left
  wire        end_char_pulse = shift_strobe & dir_out_r &
                               (shift_r[10:1] == 10'h000);

  wire rx_done = rx_end & !rx_is_break;
  wire brk_ev  = rx_end & rx_is_break;

  // command flip-flops
  always @(posedge ref_clk)
    if (clr)
    begin
      dir_out_r  <= 1'b0;
      echo_blk_r <= 1'b1;
      int_en_r   <= 1'b0;
      armed_r    <= 1'b0;
      fast_r     <= (SPEED_CTL == 0);
      dur_r      <= 1'b1;
    end
    else if (command_strobe)
    begin
      if (cmd_in)
        dir_out_r <= 1'b0;
      else if (output_direction_cmd)
        dir_out_r <= 1'b1;
      if (cmd_blk)
        echo_blk_r <= 1'b1;
      else if (cmd_unblk)
        echo_blk_r <= 1'b0;
      // enable also arms; disable disarms only with the arm option
      if (cmd_ena)
      begin
        int_en_r <= 1'b1;
        armed_r  <= 1'b1;
      end
      else if (cmd_dis)
      begin
        int_en_r <= 1'b0;
        if (ARM_OPT != 0)
          armed_r <= 1'b0;
      end
      // without speed control the rate is pinned to divide by four
      if (SPEED_CTL != 0 && ctl_code == `KBPSA_CTL_SLOW)
        fast_r <= 1'b0;
      else if (SPEED_CTL != 0 && ctl_code == `KBPSA_CTL_FAST)
        fast_r <= 1'b1;
      if (DUR_CTL != 0 && ctl_code == `KBPSA_CTL_DUR_ON)
        dur_r <= 1'b1;
      else if (DUR_CTL != 0 && ctl_code == `KBPSA_CTL_DUR_OFF)
        dur_r <= 1'b0;
    end

  // shifter and timer run flag, shared by both directions
  always @(posedge ref_clk)
    if (clr || dir_chg)
    begin
      bit_timer_run <= 1'b0;
      shift_r       <= `KBPSA_SHIFT_PRESET;
    end
    else if (tx_take)
    begin
      shift_r       <= load_frame(fifo_data);
      bit_timer_run <= 1'b1;
    end
    else if (rx_start)
    begin
      shift_r       <= `KBPSA_SHIFT_PRESET;
      bit_timer_run <= 1'b1;
    end
    else if (shift_strobe && dir_out_r)
    begin
      shift_r <= {1'b0, shift_r[10:1]};
      if (end_char_pulse)
        bit_timer_run <= 1'b0;
    end
    else if (shift_strobe)
    begin
      shift_r <= rx_nxt;
      if (rx_end)
        bit_timer_run <= 1'b0;
    end

  // receive holding buffer, overrun and break
  // a byte landing in the same cycle as a read or status read wins
  always @(posedge ref_clk)
    if (clr)
    begin
      rxbuf_r         <= 8'h00;
      avail_r         <= 1'b0;
      ovr_r           <= 1'b0;
      line_break_flag <= 1'b0;
      rx_wait_r       <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        rxbuf_r <= rx_nxt[8:1];
        avail_r <= 1'b1;
      end
      else if (brk_ev)
      begin
        rxbuf_r <= 8'h00;
        avail_r <= 1'b0;
      end
      else if (data_read_strobe)
        avail_r <= 1'b0;
      if (rx_done && avail_r && !data_read_strobe)
        ovr_r <= 1'b1;
      else if (status_read_strobe)
        ovr_r <= 1'b0;
      if (brk_ev)
        line_break_flag <= 1'b1;
      else if (rx_s)
        line_break_flag <= 1'b0;
      // a missing stop bit waits for mark before hunting again
      if (rx_end && !rx_s)
        rx_wait_r <= 1'b1;
      else if (rx_s)
        rx_wait_r <= 1'b0;
    end

  // attention: set wins over acknowledge
  wire event_any = end_char_pulse | to_out | rx_done | brk_ev;

  always @(posedge ref_clk)
    if (clr)
      attention_ff <= 1'b0;
    else if (ARM_OPT != 0 && !armed_r)
      attention_ff <= 1'b0;
    else if (event_any)
      attention_ff <= 1'b1;
    else if (intr_ack)
      attention_ff <= 1'b0;

  // pending requests survive disable and appear on enable, unless the arm option is set
  assign intr_req = attention_ff & int_en_r;

  // line driver: mark when idle, echo keyboard when unblocked
  always @(posedge ref_clk)
    if (clr)
      tx_line_r <= 1'b1;
    else if (dir_out_r && bit_timer_run)
      tx_line_r <= shift_r[0];
    else if (!dir_out_r && !echo_blk_r)
      tx_line_r <= rx_s;
    else
      tx_line_r <= 1'b1;

  // busy meaning depends on direction
  wire busy_flag = dir_out_r ? bit_timer_run : !avail_r;
  wire summary_alert    = line_break_flag | ovr_r;
  wire unit_unavailable = unavail_s;
  wire standby_or_ringing = standby_s;

  // status image refreshed every cycle
  always @(posedge ref_clk)
    if (!rstn)
      status_r <= 8'h00;
    else
    begin
      status_r <= 8'h00;
      status_r[`KBPSA_ST_OVERRUN] <= ovr_r;
      status_r[`KBPSA_ST_BREAK]   <= line_break_flag;
      status_r[`KBPSA_ST_STANDBY] <= standby_or_ringing;
      status_r[`KBPSA_ST_BUSY]    <= busy_flag;
      status_r[`KBPSA_ST_SUMMARY] <= summary_alert;
      status_r[`KBPSA_ST_UNAVAIL] <= unit_unavailable;
    end

  assign status_data     = status_r;
  assign read_data       = rxbuf_r;
  assign serial_tx_out   = tx_line_r;
  assign data_unit_ready = dur_r;

endmodule
`default_nettype wire

// ===== bench/kbpsa_adapter_props.sv
// concurrent checks on the serial adapter top ports
`timescale 1ns/100ps
`default_nettype none
module kbpsa_adapter_props (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       system_clear,
  // processor side
  input wire logic       command_strobe,
  input wire logic [7:0] command_data,
  input wire logic       status_read_strobe,
  input wire logic       data_read_strobe,
  input wire logic [7:0] status_data,
  input wire logic       intr_ack,
  input wire logic       intr_req,
  // terminal side
  input wire logic       unavailable_in,
  input wire logic       serial_tx_out
);
  reg out_r;
  reg en_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // direction and enable as last commanded; input wins over output
  always @(posedge ref_clk)
  begin
    if (!rstn || system_clear)
    begin
      out_r <= 1'b0;
      en_r  <= 1'b0;
    end
    else if (command_strobe)
    begin
      if (command_data[5])
        out_r <= 1'b0;
      else if (command_data[4])
        out_r <= 1'b1;
      if (command_data[1])
        en_r <= 1'b1;
      else if (command_data[0])
        en_r <= 1'b0;
    end
  end
  // switch from input to output with interrupts on
  sequence s_to_output;
    command_strobe && command_data[4] && !command_data[5] &&
      command_data[1] && !out_r && !system_clear;
  endsequence
  // clear, then quiet interrupt and a fresh status one edge later
  sequence s_cleared;
    !intr_req ##1 (status_data[4] && !status_data[0]);
  endsequence
  chk_switch_irq: assert property (s_to_output |=> intr_req)
    else $error("no interrupt on switch to output");
  chk_clear_quiet: assert property (system_clear |=> s_cleared)
    else $error("clear left interrupt or status");
  chk_irq_gated: assert property (intr_req |-> en_r)
    else $error("interrupt while disabled");
  chk_unused_zero: assert property (!status_data[1] && !status_data[6])
    else $error("unused status bits set");
  chk_summary_bit: assert property (
    status_data[5] == (status_data[0] || status_data[2]))
    else $error("summary bit wrong");
  chk_unavail_seen: assert property (
    $rose(unavailable_in) |-> ##[1:4] status_data[7])
    else $error("unavailable not reported");
  chk_overrun_clr: assert property (
    status_read_strobe |=> ##1 !status_data[0])
    else $error("overrun not cleared by status read");
  chk_read_busy: assert property (
    data_read_strobe && !out_r && !command_strobe |=> ##1 status_data[4])
    else $error("busy not back after read");
  chk_idle_mark: assert property (
    out_r && $past(out_r) && !status_data[4] |-> serial_tx_out)
    else $error("output not marking while idle");
  // an acknowledge just after the end may lawfully drop the request
  chk_end_irq: assert property (out_r && $past(out_r, 2) && en_r &&
    !$past(intr_ack) && $fell(status_data[4]) |-> intr_req && serial_tx_out)
    else $error("end of character without interrupt");
endmodule
bind kbpsa_adapter kbpsa_adapter_props i_kbpsa_adapter_props (
  .ref_clk            (ref_clk),
  .rstn               (rstn),
  .system_clear       (system_clear),
  .command_strobe     (command_strobe),
  .command_data       (command_data),
  .status_read_strobe (status_read_strobe),
  .data_read_strobe   (data_read_strobe),
  .status_data        (status_data),
  .intr_ack           (intr_ack),
  .intr_req           (intr_req),
  .unavailable_in     (unavailable_in),
  .serial_tx_out      (serial_tx_out)
);
`default_nettype wire

// ===== bench/kbpsa_term_model.sv
// terminal model: frame receiver and frame sender
`timescale 1ns/100ps
`default_nettype none
module kbpsa_term_model (
  // clock and bit period in cycles
  input  wire logic       ref_clk,
  input  wire logic [7:0] bit_cyc,
  // serial lines
  input  wire logic       serial_tx_out,
  output logic            serial_rx_in
);
  logic [7:0] got_byte;
  integer     got_count;
  integer     frame_errs;
  integer     i;
  initial
  begin
    serial_rx_in = 1'b1;
    got_byte     = 8'h00;
    got_count    = 0;
    frame_errs   = 0;
  end
  // sample at bit centres on the falling edge, away from output updates;
  // a missing second stop shows as an early start at the last sample
  always
  begin
    @(negedge serial_tx_out);
    repeat (bit_cyc / 2) @(negedge ref_clk);
    if (serial_tx_out === 1'b0)
    begin
      for (i = 0; i < 10; i = i + 1)
      begin
        repeat (bit_cyc) @(negedge ref_clk);
        if (i < 8)
          got_byte[i] = serial_tx_out;
        else if (serial_tx_out !== 1'b1)
          frame_errs = frame_errs + 1;
      end
      got_count = got_count + 1;
    end
  end
  // ten-bit frame, lsb first; a spacing stop leaves the line spacing
  task send_frame(input logic [7:0] b, input logic stop);
    integer k;
    begin
      serial_rx_in = 1'b0;
      repeat (bit_cyc) @(negedge ref_clk);
      for (k = 0; k < 9; k = k + 1)
      begin
        serial_rx_in = (k < 8) ? b[k] : stop;
        repeat (bit_cyc) @(negedge ref_clk);
      end
      serial_rx_in = stop;
    end
  endtask
  task mark_line;
    serial_rx_in = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/kbpsa_adapter_tb_top.sv
// self-checking bench for the serial adapter
`timescale 1ns/100ps
`default_nettype none
module kbpsa_adapter_tb_top;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       system_clear = 1'b0;
  logic       data_write_strobe = 1'b0;
  logic [7:0] write_data = 8'h00;
  wire        write_ready;
  logic       data_read_strobe = 1'b0;
  wire  [7:0] read_data;
  logic       command_strobe = 1'b0;
  logic [7:0] command_data = 8'h00;
  logic       status_read_strobe = 1'b0;
  wire  [7:0] status_data;
  logic       intr_ack = 1'b0;
  wire        intr_req;
  wire        serial_rx_in;
  logic       standby_in = 1'b0;
  logic       unavailable_in = 1'b0;
  wire        serial_tx_out;
  wire        data_unit_ready;
  logic [7:0] bit_cyc = 8'h40;
  integer     fail_count = 0;
  integer     n_compared = 0;
  integer     n;
  always #2.5 ref_clk = ~ref_clk;
  // short base divider: 16 cycles a bit fast, 64 slow
  kbpsa_adapter #(.BASE_DIV(4)) i_kbpsa_adapter (
    .ref_clk(ref_clk), .rstn(rstn), .system_clear(system_clear),
    .data_write_strobe(data_write_strobe), .write_data(write_data),
    .write_ready(write_ready), .data_read_strobe(data_read_strobe),
    .read_data(read_data), .command_strobe(command_strobe),
    .command_data(command_data), .status_read_strobe(status_read_strobe),
    .status_data(status_data), .intr_ack(intr_ack), .intr_req(intr_req),
    .serial_rx_in(serial_rx_in), .standby_in(standby_in),
    .unavailable_in(unavailable_in), .serial_tx_out(serial_tx_out),
    .data_unit_ready(data_unit_ready));
  kbpsa_term_model i_kbpsa_term_model (
    .ref_clk(ref_clk), .bit_cyc(bit_cyc),
    .serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in));
  task stop_test;
    begin
      $display("mismatches %0d, compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // one-cycle strobe: 0 cmd, 1 write, 2 read, 3 status, 4 ack, else clear
  task pulse(input integer s, input logic [7:0] d);
    begin
      @(negedge ref_clk);
      command_data = d;
      write_data = d;
      case (s)
        0: command_strobe = 1'b1;
        1: data_write_strobe = 1'b1;
        2: data_read_strobe = 1'b1;
        3: status_read_strobe = 1'b1;
        4: intr_ack = 1'b1;
        default: system_clear = 1'b1;
      endcase
      @(negedge ref_clk);
      {command_strobe, data_write_strobe, data_read_strobe} = 3'h0;
      {status_read_strobe, intr_ack, system_clear} = 3'h0;
    end
  endtask
  // b below 8: status bit b reaches c[0]; otherwise c frames received
  task wait_on(input integer b, input integer c);
    integer k;
    begin
      k = 0;
      while (!((b < 8) ? (status_data[b] === c[0]) :
             (i_kbpsa_term_model.got_count >= c)) && k < 3000)
      begin
        @(negedge ref_clk);
        k = k + 1;
      end
      if (k == 3000)
      begin
        fail_count = fail_count + 1;
        $display("unexpected timeout waiting on %0d", b);
        stop_test;
      end
    end
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("status", 8'h10, status_data);
    check("tx idle", 8'h01, {7'h00, serial_tx_out});
    check("unit ready", 8'h01, {7'h00, data_unit_ready});
    // slow receive; interrupt held back until enabled
    i_kbpsa_term_model.send_frame(8'hA5, 1'b1);
    wait_on(4, 0);
    check("rx byte", 8'hA5, read_data);
    check("irq", 8'h00, {7'h00, intr_req});
    pulse(0, 8'h02);
    check("irq", 8'h01, {7'h00, intr_req});
    pulse(4, 8'h00);
    pulse(2, 8'h00);
    @(negedge ref_clk);
    check("status", 8'h10, status_data);
    // two frames unread: overrun, then cleared by status read
    i_kbpsa_term_model.send_frame(8'h5A, 1'b1);
    i_kbpsa_term_model.send_frame(8'hC3, 1'b1);
    @(negedge ref_clk);
    check("status", 8'h21, status_data);
    check("rx byte", 8'hC3, read_data);
    pulse(3, 8'h00);
    @(negedge ref_clk);
    check("status", 8'h00, status_data);
    pulse(2, 8'h00);
    // held spacing line reads as break with an empty buffer
    i_kbpsa_term_model.send_frame(8'h00, 1'b0);
    repeat (4) @(negedge ref_clk);
    check("break", 8'h24, status_data & 8'h24);
    check("rx byte", 8'h00, read_data);
    i_kbpsa_term_model.mark_line;
    wait_on(2, 0);
    // pending request hidden by disable, shown again on enable
    pulse(0, 8'h01);
    check("irq", 8'h00, {7'h00, intr_req});
    pulse(0, 8'h02);
    check("irq", 8'h01, {7'h00, intr_req});
    pulse(2, 8'h00);
    standby_in = 1'b1;
    unavailable_in = 1'b1;
    repeat (5) @(negedge ref_clk);
    check("flags", 8'h88, status_data & 8'h88);
    standby_in = 1'b0;
    unavailable_in = 1'b0;
    // fast output with interrupts: back-to-back eleven-bit frames
    pulse(4, 8'h00);
    pulse(0, 8'hD2);
    check("irq", 8'h01, {7'h00, intr_req});
    pulse(4, 8'h00);
    bit_cyc = 8'h10;
    pulse(1, 8'h3C);
    pulse(1, 8'hC3);
    wait_on(8, 1);
    check("tx byte", 8'h3C, i_kbpsa_term_model.got_byte);
    wait_on(8, 2);
    check("tx byte", 8'hC3, i_kbpsa_term_model.got_byte);
    wait_on(4, 0);
    check("irq", 8'h01, {7'h00, intr_req});
    n = i_kbpsa_term_model.frame_errs;
    check("stop bits", 8'h00, n[7:0]);
    // fill the buffer until refused, then clear flushes it
    n = 0;
    while (write_ready === 1'b1 && n < 20)
    begin
      pulse(1, n[7:0]);
      n = n + 1;
    end
    check("accepted", 8'h11, n[7:0]);
    pulse(5, 8'h00);
    check("ready", 8'h01, {7'h00, write_ready});
    check("irq", 8'h00, {7'h00, intr_req});
    @(negedge ref_clk);
    check("status", 8'h10, status_data);
    stop_test;
  end
endmodule
`default_nettype wire
